// file: include/audio_port_pkg.sv
// Constants and types shared by the serial audio slave port
package audio_port_pkg;

    // ************************************************
    // Clock rates and derived counts
    // ************************************************
    localparam int unsigned CLOCK_HZ       = 10000000;
    localparam int unsigned BCLK_16K_HZ    = 1024000;
    localparam int unsigned BCLK_48K_HZ    = 3072000;
    localparam int unsigned BCLK_MID_HZ    = (BCLK_16K_HZ + BCLK_48K_HZ) / 2;
    localparam int unsigned FAST_PERIOD_CYC = CLOCK_HZ / BCLK_MID_HZ;
    localparam int unsigned IDLE_TIMEOUT_NS  = 6400;
    localparam int unsigned IDLE_TIMEOUT_CYC =
        (IDLE_TIMEOUT_NS * (CLOCK_HZ / 1000000)) / 1000;

    // ************************************************
    // Frame layout
    // ************************************************
    localparam int unsigned SAMPLE_WIDTH   = 32;
    localparam int unsigned FRAME_BITS     = 64;
    localparam logic [5:0]  LAST_FRAME_BIT = 6'h3f;

    // ************************************************
    // Reset values
    // ************************************************
    localparam logic [7:0]  PERIOD_RESET   = 8'h00;
    localparam logic [9:0]  RATIO_RESET    = 10'h000;

    // ************************************************
    // Types
    // ************************************************
    typedef enum logic
    {
        RATE_16K,
        RATE_48K
    } rate_t;

    typedef struct packed
    {
        logic [SAMPLE_WIDTH-1:0] left;
        logic [SAMPLE_WIDTH-1:0] right;
    } stereo_t;

endpackage

// file: hw/audio_serial_slave.sv
// Serial audio slave port: stereo in, stereo out on one host clock set
`timescale 1ns/1ps
`default_nettype none

module audio_serial_slave
(
    // Clock and reset
    input  wire logic                    clock_i,
    input  wire logic                    resetn_i,
    // Link pins to and from the host
    input  wire logic                    master_clock_in_i,
    input  wire logic                    bit_clock_in_i,
    input  wire logic                    frame_select_clock_in_i,
    input  wire logic                    serial_data_in_i,
    output logic                         serial_data_out_o,
    // Configuration
    input  wire audio_port_pkg::rate_t   rate_select_i,
    input  wire logic [9:0]              mclk_ratio_i,
    // Voice audio to send
    input  wire audio_port_pkg::stereo_t tx_frame_i,
    output logic                         tx_taken_o,
    // Reference audio received
    output audio_port_pkg::stereo_t      rx_frame_o,
    output logic                         rx_valid_o,
    // Status
    output logic                         clocks_active_o,
    output audio_port_pkg::rate_t        detected_rate_o,
    output logic                         rate_ok_o,
    output logic                         frame_error_o,
    output logic                         sample_tick_o
);
    import audio_port_pkg::*;
    default clocking assert_clock @(posedge clock_i);
    endclocking
    default disable iff (!resetn_i);

    // ************************************************
    // Pin synchronisers
    // ************************************************
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic       bclk_d_reg;
    logic       mclk_d_reg;
    logic       ws_prev_reg;

    always_ff @(posedge clock_i)
    begin
        if (!resetn_i)
        begin
            sync1_reg <= 4'h0;
            sync2_reg <= 4'h0;
            bclk_d_reg <= 1'b0;
            mclk_d_reg <= 1'b0;
        end
        else
        begin
            sync1_reg <= {master_clock_in_i, bit_clock_in_i,
                          frame_select_clock_in_i, serial_data_in_i};
            sync2_reg <= sync1_reg;
            bclk_d_reg <= sync2_reg[2];
            mclk_d_reg <= sync2_reg[3];
        end
    end

    logic bclk_rise;
    logic bclk_fall;
    logic mclk_rise;
    logic ws_now;
    logic din_now;
    logic ws_change;
    assign bclk_rise = sync2_reg[2] & ~bclk_d_reg;
    assign bclk_fall = ~sync2_reg[2] & bclk_d_reg;
    assign mclk_rise = sync2_reg[3] & ~mclk_d_reg;
    assign ws_now    = sync2_reg[1];
    assign din_now   = sync2_reg[0];
    assign ws_change = bclk_rise & (ws_now != ws_prev_reg);

    // ************************************************
    // Receive path
    // ************************************************
    logic [SAMPLE_WIDTH-1:0] rx_shift_reg;
    logic [SAMPLE_WIDTH-1:0] rx_word;
    assign rx_word = {rx_shift_reg[SAMPLE_WIDTH-2:0], din_now};

    always_ff @(posedge clock_i)
    begin
        if (!resetn_i)
        begin
            ws_prev_reg <= 1'b0;
            rx_shift_reg <= '0;
            rx_frame_o <= '0;
            rx_valid_o <= 1'b0;
        end
        else
        begin
            rx_valid_o <= 1'b0;
            if (bclk_rise)
            begin
                ws_prev_reg <= ws_now;
                rx_shift_reg <= rx_word;
                if (ws_change)
                begin
                    if (ws_prev_reg)
                    begin
                        rx_frame_o.right <= rx_word;
                        rx_valid_o <= 1'b1;
                    end
                    else
                    begin
                        rx_frame_o.left <= rx_word;
                    end
                end
            end
        end
    end

    // ************************************************
    // Transmit path, same clock pair as receive
    // ************************************************
    logic [SAMPLE_WIDTH-1:0] tx_shift_reg;
    logic [SAMPLE_WIDTH-1:0] tx_right_reg;

    always_ff @(posedge clock_i)
    begin
        if (!resetn_i)
        begin
            tx_shift_reg <= '0;
            tx_right_reg <= '0;
            tx_taken_o <= 1'b0;
            serial_data_out_o <= 1'b0;
        end
        else
        begin
            tx_taken_o <= 1'b0;
            if (ws_change)
            begin
                if (!ws_now)
                begin
                    tx_shift_reg <= tx_frame_i.left;
                    tx_right_reg <= tx_frame_i.right;
                    tx_taken_o <= 1'b1;
                end
                else
                begin
                    tx_shift_reg <= tx_right_reg;
                end
            end
            else if (bclk_fall)
            begin
                serial_data_out_o <= tx_shift_reg[SAMPLE_WIDTH-1];
                tx_shift_reg <= {tx_shift_reg[SAMPLE_WIDTH-2:0], 1'b0};
            end
        end
    end

    // ************************************************
    // Frame length check
    // ************************************************
    logic [5:0] bit_count_reg;
    logic       framed_reg;

    always_ff @(posedge clock_i)
    begin
        if (!resetn_i)
        begin
            bit_count_reg <= 6'h00;
            framed_reg <= 1'b0;
            frame_error_o <= 1'b0;
        end
        else if (ws_change && !ws_now)
        begin
            bit_count_reg <= 6'h00;
            framed_reg <= 1'b1;
            frame_error_o <= framed_reg && (bit_count_reg != LAST_FRAME_BIT);
        end
        else if (bclk_rise)
        begin
            bit_count_reg <= bit_count_reg + 6'h01;
        end
    end

    // ************************************************
    // Clock activity and rate detection
    // ************************************************
    logic [7:0] idle_count_reg;
    logic [7:0] period_reg;

    always_ff @(posedge clock_i)
    begin
        if (!resetn_i)
        begin
            idle_count_reg <= 8'h00;
            clocks_active_o <= 1'b0;
            period_reg <= PERIOD_RESET;
            detected_rate_o <= RATE_16K;
            rate_ok_o <= 1'b0;
        end
        else
        begin
            if (bclk_rise)
            begin
                idle_count_reg <= 8'h00;
                clocks_active_o <= 1'b1;
                period_reg <= PERIOD_RESET;
                detected_rate_o <= (period_reg < 8'(FAST_PERIOD_CYC + 1))
                                   ? RATE_48K : RATE_16K;
            end
            else
            begin
                if (period_reg != 8'hff)
                begin
                    period_reg <= period_reg + 8'h01;
                end
                if (idle_count_reg == 8'(IDLE_TIMEOUT_CYC))
                begin
                    clocks_active_o <= 1'b0;
                end
                else
                begin
                    idle_count_reg <= idle_count_reg + 8'h01;
                end
            end
            rate_ok_o <= clocks_active_o && (detected_rate_o == rate_select_i);
        end
    end

    // ************************************************
    // Master clock divider to sample ticks
    // ************************************************
    logic [9:0] mclk_count_reg;

    always_ff @(posedge clock_i)
    begin
        if (!resetn_i)
        begin
            mclk_count_reg <= RATIO_RESET;
            sample_tick_o <= 1'b0;
        end
        else
        begin
            sample_tick_o <= 1'b0;
            if (mclk_rise)
            begin
                if (mclk_count_reg + 10'h001 >= mclk_ratio_i)
                begin
                    mclk_count_reg <= RATIO_RESET;
                    sample_tick_o <= 1'b1;
                end
                else
                begin
                    mclk_count_reg <= mclk_count_reg + 10'h001;
                end
            end
        end
    end

    // ************************************************
    // Assertions
    // ************************************************
    property p_out_on_fall;
        $changed(serial_data_out_o) |-> $past(bclk_fall);
    endproperty
    a_out_on_fall: assert property (p_out_on_fall)
        else $error("Data out changed away from a bit clock fall");
    property p_msb_out;
        (bclk_fall && !ws_change) |=>
            (serial_data_out_o == $past(tx_shift_reg[SAMPLE_WIDTH-1]));
    endproperty
    a_msb_out: assert property (p_msb_out)
        else $error("Data out is not the top bit of the word");
    property p_rx_right;
        rx_valid_o |-> $past(ws_change && ws_prev_reg);
    endproperty
    a_rx_right: assert property (p_rx_right)
        else $error("Frame valid without end of right channel");
    property p_rx_word;
        rx_valid_o |-> (rx_frame_o.right == $past(rx_word)) ##1 !rx_valid_o;
    endproperty
    a_rx_word: assert property (p_rx_word)
        else $error("Received right word wrong or valid too long");
    property p_tx_taken;
        tx_taken_o |-> $past(ws_change && !ws_now);
    endproperty
    a_tx_taken: assert property (p_tx_taken)
        else $error("Transmit frame taken away from left start");
    property p_active;
        bclk_rise |=> clocks_active_o [*2];
    endproperty
    a_active: assert property (p_active)
        else $error("Clock activity not flagged after bit clock edge");
    property p_rate;
        ##1 rate_ok_o == ($past(clocks_active_o) &&
                          ($past(detected_rate_o) == $past(rate_select_i)));
    endproperty
    a_rate: assert property (p_rate)
        else $error("Rate status does not match configuration");
    property p_tick;
        sample_tick_o |-> $past(mclk_rise) ##1 !sample_tick_o;
    endproperty
    a_tick: assert property (p_tick)
        else $error("Sample tick without master clock edge");
    property p_frame_len;
        (ws_change && !ws_now && framed_reg) |=>
            (frame_error_o == ($past(bit_count_reg) != LAST_FRAME_BIT));
    endproperty
    a_frame_len: assert property (p_frame_len)
        else $error("Frame length flag wrong");
    property p_slave_only;
        (tx_taken_o || rx_valid_o) |-> clocks_active_o;
    endproperty
    a_slave_only: assert property (p_slave_only)
        else $error("Port moved data without host clocks");

    c_frame_rx: cover property (rx_valid_o);
    c_frame_tx: cover property (tx_taken_o ##1 !tx_taken_o [*8]);
    c_rate_ok: cover property ($rose(rate_ok_o));
    c_tick: cover property (sample_tick_o);

endmodule

`default_nettype wire

// file: test/i2s_host_model.sv
// Host side audio serial master: makes all link clocks and the data in stream, samples data out
`timescale 1ns/1ps
`default_nettype none

module i2s_host_model
(
    // Control from the bench
    input  wire logic                    run_i,
    input  wire logic [5:0]              last_bit_i,
    input  wire audio_port_pkg::stereo_t words_i,
    // Link pins
    output logic                         mclk_o,
    output logic                         bclk_o,
    output logic                         lrck_o,
    output logic                         din_o,
    input  wire logic                    dout_i,
    // Words heard from the port
    output audio_port_pkg::stereo_t      heard_o
);
    import audio_port_pkg::*;

    // ************************************************
    // Bit clock, frame clock and data
    // ************************************************
    initial
    begin
        bclk_o  = 1'b0;
        lrck_o  = 1'b0;
        din_o   = 1'b0;
        heard_o = '0;
        #37;
        forever
        begin
            if (run_i !== 1'b1)
            begin
                // Clocks stand still, released data line keeps changing
                din_o = ~din_o;
                #400;
            end
            else
            begin
                for (int i = 0; i <= int'(last_bit_i); i++)
                begin
                    lrck_o = (i >= 32);
                    din_o  = words_i[63 - ((i + 63) % 64)];
                    #400;
                    bclk_o = 1'b1;
                    heard_o[63 - ((i + 63) % 64)] = dout_i;
                    #400;
                    bclk_o = 1'b0;
                end
            end
        end
    end

    // ************************************************
    // Master audio clock, 2.5 MHz while running
    // ************************************************
    initial
    begin
        mclk_o = 1'b0;
        forever
        begin
            if (run_i === 1'b1)
            begin
                mclk_o = 1'b1;
                #200;
                mclk_o = 1'b0;
                #200;
            end
            else
            begin
                #400;
            end
        end
    end
endmodule

`default_nettype wire

// file: test/i2s_slave_audio_port_tb_top.sv
// Self-checking bench of the serial audio slave port
`timescale 1ns/1ps
`default_nettype none

module i2s_slave_audio_port_tb_top;
    import audio_port_pkg::*;

    // ************************************************
    // Signals
    // ************************************************
    logic        clock_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic        mclk, bclk, lrck, din, dout, tx_taken, rx_valid;
    logic        active, rate_ok, frame_err, tick, run = 1'b0;
    logic [5:0]  last_bit = 6'h3f;
    logic [9:0]  ratio = 10'h004;
    rate_t       rate_sel = RATE_16K;
    rate_t       rate_det;
    stereo_t     tx_words = 64'h8123_4567_9abc_def1;
    stereo_t     rx_words = 64'hc0de_5a5a_a5a5_0bd3;
    stereo_t     rx_frame, heard;
    int          fail_count = 0;
    int          samples_checked = 0;
    int          taken_count = 0;
    int          mclk_rises = 0;

    always #50 clock_i = ~clock_i;
    always @(negedge clock_i) if (tx_taken === 1'b1) taken_count++;
    always @(posedge mclk) mclk_rises++;

    audio_serial_slave uut
    (
        .clock_i                 (clock_i),
        .resetn_i                (resetn_i),
        .master_clock_in_i       (mclk),
        .bit_clock_in_i          (bclk),
        .frame_select_clock_in_i (lrck),
        .serial_data_in_i        (din),
        .serial_data_out_o       (dout),
        .rate_select_i           (rate_sel),
        .mclk_ratio_i            (ratio),
        .tx_frame_i              (tx_words),
        .tx_taken_o              (tx_taken),
        .rx_frame_o              (rx_frame),
        .rx_valid_o              (rx_valid),
        .clocks_active_o         (active),
        .detected_rate_o         (rate_det),
        .rate_ok_o               (rate_ok),
        .frame_error_o           (frame_err),
        .sample_tick_o           (tick)
    );

    i2s_host_model host
    (
        .run_i      (run),
        .last_bit_i (last_bit),
        .words_i    (rx_words),
        .mclk_o     (mclk),
        .bclk_o     (bclk),
        .lrck_o     (lrck),
        .din_o      (din),
        .dout_i     (dout),
        .heard_o    (heard)
    );

    // ************************************************
    // Shared tasks
    // ************************************************
    task automatic test_done();
        if (fail_count == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wait_rx(input int frames);
        for (int f = 0; f < frames; f++)
        begin
            int n;
            n = 0;
            @(negedge clock_i);
            while (rx_valid !== 1'b1 && n < 1500)
            begin
                @(negedge clock_i);
                n++;
            end
            if (n == 1500)
            begin
                fail_count++;
                test_done();
            end
        end
        repeat (5) @(negedge clock_i);
    endtask

    // ************************************************
    // Scenarios
    // ************************************************
    task automatic reset_state();
        repeat (5) @(negedge clock_i);
        check({rx_valid, tx_taken, active, rate_ok, frame_err, dout}, 0);
        check(rx_frame, 0);
        resetn_i = 1'b1;
    endtask

    task automatic stream_both_ways();
        run = 1'b1;
        wait_rx(1);
        check(rx_frame, rx_words);
        wait_rx(2);
        check(rx_frame, rx_words);
        check(heard, tx_words);
        check(taken_count > 1, 1'b1);
        check({active, rate_ok, frame_err}, 3'h6);
        check(rate_det, RATE_16K);
    endtask

    task automatic rate_mismatch();
        rate_sel = RATE_48K;
        repeat (4) @(negedge clock_i);
        check(rate_ok, 1'b0);
        rate_sel = RATE_16K;
        repeat (4) @(negedge clock_i);
        check(rate_ok, 1'b1);
    endtask

    task automatic tick_spacing();
        int n;
        for (int k = 0; k < 2; k++)
        begin
            n = 0;
            @(negedge clock_i);
            while (tick !== 1'b1 && n < 100)
            begin
                @(negedge clock_i);
                n++;
            end
            check(n < 100, 1'b1);
            if (n == 100) test_done();
            if (k == 0) mclk_rises = 0;
        end
        check(mclk_rises, 4);
    endtask

    task automatic short_frame();
        last_bit = 6'h3d;
        wait_rx(3);
        check(frame_err, 1'b1);
        last_bit = LAST_FRAME_BIT;
        wait_rx(3);
        check(frame_err, 1'b0);
        check(rx_frame, rx_words);
    endtask

    task automatic stop_clocks();
        run = 1'b0;
        repeat (700) @(negedge clock_i);
        check(active, 1'b0);
    endtask

    initial
    begin
        reset_state();
        stream_both_ways();
        rate_mismatch();
        tick_spacing();
        short_frame();
        stop_clocks();
        test_done();
    end
endmodule

`default_nettype wire
